// [rtl/awu_consts.vh]
// Constants of the auto wake-up from halt timer: offsets, fields, resets and timing
`ifndef AWU_CONSTS_VH
`define AWU_CONSTS_VH

// Register indices; the byte address is four times the index
`define AWU_CSR_IDX          10'h048
`define AWU_PRESCALER_IDX    10'h049
`define AWU_INT_STATUS_IDX   10'h04A
`define AWU_INT_MASK_IDX     10'h04B

// Control/status field positions
`define AWU_CSR_ENABLE_BIT   0
`define AWU_CSR_MEASURE_BIT  1
`define AWU_CSR_FLAG_BIT     2

// Interrupt status/mask field positions
`define AWU_INT_WAKE_BIT     0
`define AWU_INT_EXIT_BIT     1

// Reset values
`define AWU_CSR_RESET        8'h00
`define AWU_PRESCALER_RESET  8'hFF
`define AWU_INT_RESET        2'h0

// Timing
`define AWU_CLK_PERIOD_NS    5
`define AWU_RC_FIXED_DIV     64
`define AWU_STAB_CYCLES      256
`define AWU_DIV_LAST         6'h3F
`define AWU_STAB_LAST        9'h0FF
`define AWU_RC_STARTUP_NS    1000
`define AWU_RC_STARTUP_CYC   ((`AWU_RC_STARTUP_NS + `AWU_CLK_PERIOD_NS - 1) / `AWU_CLK_PERIOD_NS)

// Sequencer states
`define AWU_ST_RUN           2'h0
`define AWU_ST_AWU_HALT      2'h1
`define AWU_ST_HALT          2'h2
`define AWU_ST_STAB          2'h3

`endif

// [rtl/awu_wake_timer.v]
// Auto wake-up from halt timer with APB register slave and halt sequencer
// Register map, as seen over the bus (byte addresses, one word each)
//   control/status : bit 0 wake enable, bit 1 measure enable, bit 2 wake flag
//   prescaler      : eight bits, the dividing factor, never zero
//   int status     : bit 0 wake elapsed, bit 1 halt left by an outside interrupt
//   int mask       : same layout as int status
// Upper bits of every register read as zero; writes to them go nowhere.
// An address outside the map answers with an error and has no effect.
//
// Bus timing
//   Every access waits one cycle: pready rises in the second access cycle.
//   Read data is registered, so the read mux is off the critical path.
//   The trade is one extra cycle per access, which software never notices.
//   Writes and read side effects land on the edge that sees pready high.
//
// Halt sequencer
//   run        : CPU clocked; a halt pulse leaves for one of the halt states.
//   auto halt  : main oscillator off, RC clock counts towards the wake-up.
//   plain halt : main oscillator off, only an outside interrupt leaves it.
//   stabilise  : main oscillator on again, CPU held for the settling time.
// The watchdog option is checked before either halt state is chosen.
//
// Wake-up timing in auto halt
//   First the RC oscillator start-up time is counted in core cycles.
//   Then each rising RC edge steps the fixed divide-by-64 counter.
//   Each wrap of that counter steps the prescaler counter.
//   The last edge of the last prescaler step raises the elapse strobe.
//   The prescaler is read live; software must not change it while halted
//   unless it accepts a period of mixed length.
//
// Hazards and limitations
//   The RC clock is a level input sampled on the core clock, so it must be
//   well below half the core rate; faster RC clocks lose edges.
//   A wake flag already set at auto halt entry wakes at once, because the
//   interrupt mask is cleared on entry and the request is still pending.
//   Hardware set beats a software clear in the same cycle, so no event
//   is lost between a read and a new elapse.
//   The capture output is a registered copy of the RC level gated by measure enable, one core
//   cycle late; a measurement sees that fixed offset on every edge alike.
//
// Outputs to the rest of the chip
//   autoWakeHaltMode, haltActive : current halt state, registered
//   mainOscOn, peripheralClkEn   : clock gating requests, registered
//   cpuRun                       : high only while the CPU may execute
//   intMaskClear                 : one-cycle pulse on every halt entry
//   watchdogReset                : one-cycle pulse for a refused halt
//   irq, cpuWakeIrq              : level requests to the interrupt logic
//
// Reset gives run state, oscillator on, all flags clear, prescaler all ones.
`include "awu_consts.vh"
`default_nettype none

module awu_wake_timer #(
    parameter integer PADDR_W        = 12,
    parameter integer RC_STARTUP_CYC = `AWU_RC_STARTUP_CYC
) (
    input  wire               core_clk,
    input  wire               rst,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [PADDR_W-1:0] paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output reg                pready,
    output reg                pslverr,
    input  wire               rcClk,
    input  wire               haltExec,
    input  wire               watchdogEnabled,
    input  wire               watchdogHaltOption,
    input  wire               exitIrq,
    output wire               irq,
    output wire               cpuWakeIrq,
    output reg                autoWakeHaltMode,
    output reg                haltActive,
    output reg                mainOscOn,
    output reg                peripheralClkEn,
    output reg                cpuRun,
    output reg                rcOscEnable,
    output reg                rcCaptureIn,
    output reg                intMaskClear,
    output reg                watchdogReset
);

    // Byte address of a register index; the two low address bits are always zero
    function [PADDR_W-1:0] regAddr;
        input [9:0] idx;
        begin
            regAddr = {idx[PADDR_W-3:0], 2'b00};
        end
    endfunction

    // True in either halt state; shared by the exit detector and the halt output
    function inHalt;
        input [1:0] st;
        begin
            inHalt = (st == `AWU_ST_AWU_HALT) || (st == `AWU_ST_HALT);
        end
    endfunction

    // Reset image of control/status, so each bit reset is a plain select
    localparam [7:0] CSR_RST = `AWU_CSR_RESET;

    // Software-visible state
    reg        wakeEnable;
    reg        measureEnable;
    reg        wakeFlag;
    reg [7:0]  prescaler;
    reg [1:0]  intStatus;
    reg [1:0]  intMask;

    // Halt sequencer and its counters
    reg [1:0]  state;
    reg [1:0]  next_state;
    reg [15:0] startCnt;
    reg [5:0]  divCnt;
    reg [7:0]  presCnt;
    reg [8:0]  stabCnt;

    // RC edge detector and the elapse strobe
    reg        rcPrev;
    reg        elapsed;

    // Bus decode; side effects only on the completing edge
    wire accessDone = psel & penable & pready;
    wire wrDone     = accessDone & pwrite;
    wire rdDone     = accessDone & ~pwrite;
    wire selCsr     = (paddr == regAddr(`AWU_CSR_IDX));
    wire selPres    = (paddr == regAddr(`AWU_PRESCALER_IDX));
    wire selStat    = (paddr == regAddr(`AWU_INT_STATUS_IDX));
    wire selMask    = (paddr == regAddr(`AWU_INT_MASK_IDX));
    wire mapped     = selCsr | selPres | selStat | selMask;

    // Wake-up timing terms; rcPrev resets low like the idle RC level, so no false tick
    wire rcTick     = rcClk & ~rcPrev;
    wire startDone  = (startCnt >= RC_STARTUP_CYC[15:0]);
    wire lastDiv    = (divCnt == `AWU_DIV_LAST);
    wire lastPres   = (presCnt == prescaler - 8'h01);
    wire exitEvent  = inHalt(state) && exitIrq;

    // The wake request to the CPU lives exactly as long as the flag
    assign cpuWakeIrq = wakeFlag;
    assign irq        = |(intStatus & intMask);

    // APB answer: one wait state so read data comes from a flip-flop
    always @(posedge core_clk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (psel & penable & ~pready) begin
            pready  <= 1'b1;
            pslverr <= ~mapped;
            prdata  <= 32'h00000000;
            if (!pwrite) begin
                if (selCsr)
                    prdata[2:0] <= {wakeFlag, measureEnable, wakeEnable};
                else if (selPres)
                    prdata[7:0] <= prescaler;
                else if (selStat)
                    prdata[1:0] <= intStatus;
                else if (selMask)
                    prdata[1:0] <= intMask;
            end
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Software-owned control bits; the flag position is write-inert
    always @(posedge core_clk) begin
        if (rst) begin
            wakeEnable    <= CSR_RST[`AWU_CSR_ENABLE_BIT];
            measureEnable <= CSR_RST[`AWU_CSR_MEASURE_BIT];
            prescaler     <= `AWU_PRESCALER_RESET;
            intMask       <= `AWU_INT_RESET;
        end else if (wrDone) begin
            if (selCsr) begin
                wakeEnable    <= pwdata[`AWU_CSR_ENABLE_BIT];
                measureEnable <= pwdata[`AWU_CSR_MEASURE_BIT];
            end
            if (selPres && pwdata[7:0] != 8'h00)
                prescaler <= pwdata[7:0];
            if (selMask)
                intMask <= pwdata[1:0];
        end
    end

    // Flag: a hardware set in the same cycle as a read clear wins
    always @(posedge core_clk) begin
        if (rst)
            wakeFlag <= CSR_RST[`AWU_CSR_FLAG_BIT];
        else if (elapsed)
            wakeFlag <= 1'b1;
        else if (rdDone && selCsr)
            wakeFlag <= 1'b0;
    end

    // Sticky event bits, write one to clear, set beats clear
    always @(posedge core_clk) begin
        if (rst) begin
            intStatus <= `AWU_INT_RESET;
        end else begin
            if (elapsed)
                intStatus[`AWU_INT_WAKE_BIT] <= 1'b1;
            else if (wrDone && selStat && pwdata[`AWU_INT_WAKE_BIT])
                intStatus[`AWU_INT_WAKE_BIT] <= 1'b0;
            if (exitEvent)
                intStatus[`AWU_INT_EXIT_BIT] <= 1'b1;
            else if (wrDone && selStat && pwdata[`AWU_INT_EXIT_BIT])
                intStatus[`AWU_INT_EXIT_BIT] <= 1'b0;
        end
    end

    // Halt sequencer next state
    always @* begin
        next_state = state;
        elapsed    = 1'b0;
        case (state)
            `AWU_ST_RUN: begin
                if (haltExec && !(watchdogEnabled && watchdogHaltOption)) begin
                    if (wakeEnable)
                        next_state = `AWU_ST_AWU_HALT;
                    else
                        next_state = `AWU_ST_HALT;
                end
            end
            `AWU_ST_AWU_HALT: begin
                // A request already pending wakes at once since the mask is cleared
                if (exitIrq || wakeFlag) begin
                    next_state = `AWU_ST_STAB;
                end else if (startDone && rcTick && lastDiv && lastPres) begin
                    elapsed    = 1'b1;
                    next_state = `AWU_ST_STAB;
                end
            end
            `AWU_ST_HALT: begin
                if (exitIrq)
                    next_state = `AWU_ST_STAB;
            end
            `AWU_ST_STAB: begin
                if (stabCnt == `AWU_STAB_LAST)
                    next_state = `AWU_ST_RUN;
            end
            default: next_state = `AWU_ST_RUN;
        endcase
    end

    // State, counters and the halt-side outputs, all from flip-flops
    always @(posedge core_clk) begin
        if (rst) begin
            state            <= `AWU_ST_RUN;
            startCnt         <= 16'h0000;
            divCnt           <= 6'h00;
            presCnt          <= 8'h00;
            stabCnt          <= 9'h000;
            rcPrev           <= 1'b0;
            autoWakeHaltMode <= 1'b0;
            haltActive       <= 1'b0;
            mainOscOn        <= 1'b1;
            peripheralClkEn  <= 1'b1;
            cpuRun           <= 1'b1;
            rcOscEnable      <= 1'b0;
            rcCaptureIn      <= 1'b0;
            intMaskClear     <= 1'b0;
            watchdogReset    <= 1'b0;
        end else begin
            state  <= next_state;
            rcPrev <= rcClk;
            // Fresh counts at every entry so no halt is cut short
            if (state != `AWU_ST_AWU_HALT) begin
                startCnt <= 16'h0000;
                divCnt   <= 6'h00;
                presCnt  <= 8'h00;
            end else if (!startDone) begin
                startCnt <= startCnt + 16'h0001;
            end else if (rcTick) begin
                divCnt <= lastDiv ? 6'h00 : divCnt + 6'h01;
                if (lastDiv)
                    presCnt <= presCnt + 8'h01;
            end
            stabCnt <= (state == `AWU_ST_STAB) ? stabCnt + 9'h001 : 9'h000;
            autoWakeHaltMode <= (next_state == `AWU_ST_AWU_HALT);
            haltActive       <= inHalt(next_state);
            // Oscillator back on as soon as the wake starts
            mainOscOn        <= (next_state == `AWU_ST_RUN) ||
                                (next_state == `AWU_ST_STAB);
            peripheralClkEn  <= (next_state == `AWU_ST_RUN);
            cpuRun           <= (next_state == `AWU_ST_RUN);
            rcOscEnable      <= (next_state == `AWU_ST_AWU_HALT) || measureEnable;
            // Capture sees the RC clock only while measuring
            rcCaptureIn      <= measureEnable & rcClk;
            intMaskClear     <= (state == `AWU_ST_RUN) && (next_state != `AWU_ST_RUN);
            watchdogReset    <= (state == `AWU_ST_RUN) && haltExec &&
                                watchdogEnabled && watchdogHaltOption;
        end
    end

endmodule

`default_nettype wire

// [verif/awu_wake_timer_asserts.sv]
// Port checker of the auto wake-up timer
`default_nettype none
module awu_wake_timer_asserts (
    input wire logic        core_clk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        rcClk,
    input wire logic        haltExec,
    input wire logic        watchdogEnabled,
    input wire logic        watchdogHaltOption,
    input wire logic        cpuWakeIrq,
    input wire logic        autoWakeHaltMode,
    input wire logic        mainOscOn,
    input wire logic        cpuRun,
    input wire logic        rcOscEnable,
    input wire logic        rcCaptureIn,
    input wire logic        intMaskClear,
    input wire logic        watchdogReset
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [8:0] stabCnt;
    wire        wdHalt = haltExec && cpuRun && watchdogEnabled && watchdogHaltOption;
    // Cycles with oscillator on and CPU held; a counter since 256 is beyond a repetition
    always_ff @(posedge core_clk) begin
        if (rst || !mainOscOn || cpuRun) begin
            stabCnt <= 9'h000;
        end else begin
            stabCnt <= stabCnt + 9'h001;
        end
    end
    a_pready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_access_answer: assert property (psel && penable && !pready |=> pready)
        else $error("no answer to access");
    a_error_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error answer carries data");
    a_halt_entry: assert property (haltExec && cpuRun && !wdHalt
        |=> !cpuRun && !mainOscOn && intMaskClear ##1 !intMaskClear) else $error("bad entry");
    a_watchdog_reset: assert property (wdHalt |=> watchdogReset && cpuRun)
        else $error("watchdog halt wrong");
    a_stab_delay: assert property ($rose(cpuRun) |-> stabCnt == 9'h100)
        else $error("stabilisation not 256 cycles");
    a_wake_flag: assert property ($rose(cpuWakeIrq)
        |-> mainOscOn && !autoWakeHaltMode && !cpuRun) else $error("flag without wake");
    a_halt_quiet: assert property (autoWakeHaltMode |-> !cpuRun && !mainOscOn)
        else $error("clocks on in halt");
    a_rc_running: assert property (autoWakeHaltMode && $past(autoWakeHaltMode)
        |-> rcOscEnable) else $error("RC oscillator off in halt");
    a_capture_route: assert property (rcCaptureIn |-> $past(rcClk))
        else $error("capture not from RC clock");
    c_wake: cover property ($rose(cpuWakeIrq));
    c_wd: cover property (watchdogReset);
    c_err: cover property (pslverr);
endmodule
bind awu_wake_timer awu_wake_timer_asserts i_chk (.core_clk(core_clk), .rst(rst), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .rcClk(rcClk),
    .haltExec(haltExec), .watchdogEnabled(watchdogEnabled),
    .watchdogHaltOption(watchdogHaltOption), .cpuWakeIrq(cpuWakeIrq),
    .autoWakeHaltMode(autoWakeHaltMode), .mainOscOn(mainOscOn), .cpuRun(cpuRun),
    .rcOscEnable(rcOscEnable), .rcCaptureIn(rcCaptureIn), .intMaskClear(intMaskClear),
    .watchdogReset(watchdogReset));
`default_nettype wire

// [verif/awu_cpu_model.sv]
// Model of the CPU halt request and the wake RC oscillator
`default_nettype none
module awu_cpu_model (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic haltReq,
    input  wire logic cpuRun,
    input  wire logic rcOscEnable,
    output var  logic haltExec,
    output var  logic rcClk
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rcPhase;
    initial begin
        haltExec = 1'h0;
        rcClk = 1'h0;
        rcPhase = 1'h0;
    end
    // Halt only from run; RC clock stands still while its oscillator is off
    always @(posedge core_clk) begin
        haltExec <= haltReq && cpuRun && !rst;
        if (rst || !rcOscEnable) begin
            rcPhase <= 1'h0;
            rcClk <= 1'h0;
        end else begin
            rcPhase <= ~rcPhase;
            if (rcPhase) rcClk <= ~rcClk;
        end
    end
endmodule
`default_nettype wire

// [verif/awu_wake_timer_tb_top.sv]
// Self-checking bench of the auto wake-up timer
`include "awu_consts.vh"
`default_nettype none
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin errors++; \
    $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got); end end
module awu_wake_timer_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [11:0] CSR = {`AWU_CSR_IDX, 2'h0};
    localparam logic [11:0] PRE = {`AWU_PRESCALER_IDX, 2'h0};
    localparam logic [11:0] IST = {`AWU_INT_STATUS_IDX, 2'h0};
    localparam logic [11:0] MSK = {`AWU_INT_MASK_IDX, 2'h0};
    logic core_clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, rcClk, haltExec, irq, cpuWakeIrq, autoWakeHaltMode, haltActive;
    logic mainOscOn, peripheralClkEn, cpuRun, rcOscEnable, rcCaptureIn, intMaskClear, err;
    logic watchdogReset, haltReq = 1'h0, exitIrq = 1'h0, watchdogEnabled = 1'h0;
    logic watchdogHaltOption = 1'h0;
    int errors = 0, nCompared = 0, cycles = 0, n;
    always #2.5 core_clk = ~core_clk;
    awu_wake_timer #(.RC_STARTUP_CYC(2)) i_dut (.core_clk(core_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rcClk(rcClk), .haltExec(haltExec),
        .watchdogEnabled(watchdogEnabled), .watchdogHaltOption(watchdogHaltOption),
        .exitIrq(exitIrq), .irq(irq), .cpuWakeIrq(cpuWakeIrq), .haltActive(haltActive),
        .autoWakeHaltMode(autoWakeHaltMode), .mainOscOn(mainOscOn), .cpuRun(cpuRun),
        .peripheralClkEn(peripheralClkEn), .rcOscEnable(rcOscEnable),
        .rcCaptureIn(rcCaptureIn), .intMaskClear(intMaskClear), .watchdogReset(watchdogReset));
    awu_cpu_model i_cpu (.core_clk(core_clk), .rst(rst), .haltReq(haltReq), .cpuRun(cpuRun),
        .rcOscEnable(rcOscEnable), .haltExec(haltExec), .rcClk(rcClk));
    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge core_clk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'h1;
        do @(posedge core_clk); while (pready !== 1'h1);
        q = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wrReg(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, rd, err);
    endtask
    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        apb(1'h0, a, 32'h0, rd, err);
        `CHK(nm, exp, rd)
    endtask
    task automatic halt();
        @(posedge core_clk);
        haltReq <= 1'h1;
        @(posedge core_clk);
        haltReq <= 1'h0;
    endtask
    // Waits are cut short by the cycle ceiling below
    task automatic waitHigh(ref logic s, output int k);
        k = 0;
        while (s !== 1'h1) begin
            @(posedge core_clk);
            k++;
        end
    endtask
    task automatic finishTest();
        $display("Compared %0d, mismatches %0d", nCompared, errors);
        if (errors == 0 && nCompared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            errors++;
            finishTest();
        end
    end
    initial begin
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        rdChk(CSR, 32'h0, "csr reset");
        rdChk(PRE, 32'hFF, "prescaler reset");
        wrReg(PRE, 32'h0);
        rdChk(PRE, 32'hFF, "prescaler zero write");
        wrReg(CSR, 32'hFF);
        rdChk(CSR, 32'h3, "csr writable bits");
        apb(1'h0, 12'h130, 32'h0, rd, err);
        `CHK("unmapped error", 1'h1, err)
        $display("registers done");
        wrReg(CSR, 32'h2);
        waitHigh(rcCaptureIn, n);
        `CHK("rc enable", 1'h1, rcOscEnable)
        wrReg(MSK, 32'h3);
        for (int p = 1; p <= 2; p++) begin
            wrReg(PRE, 32'(p));
            wrReg(CSR, 32'h1);
            halt();
            waitHigh(cpuWakeIrq, n);
            `CHK("halt length", 1'h1, n >= 256 * p - 4 && n <= 256 * p + 12)
            `CHK("irq", 1'h1, irq)
            waitHigh(cpuRun, n);
            rdChk(CSR, 32'h5, "flag set");
            rdChk(CSR, 32'h1, "flag cleared");
            `CHK("wake irq cleared", 1'h0, cpuWakeIrq)
            rdChk(IST, 32'h1, "wake status");
            wrReg(IST, 32'h1);
            rdChk(IST, 32'h0, "status cleared");
            `CHK("irq cleared", 1'h0, irq)
            $display("auto halt done");
        end
        watchdogEnabled <= 1'h1;
        wrReg(CSR, 32'h0);
        halt();
        repeat (2) @(posedge core_clk);
        `CHK("plain halt", 1'h0, cpuRun)
        `CHK("not auto halt", 1'h0, autoWakeHaltMode)
        `CHK("halt active", 1'h1, haltActive)
        `CHK("osc off", 1'h0, mainOscOn)
        `CHK("periph off", 1'h0, peripheralClkEn)
        exitIrq <= 1'h1;
        waitHigh(cpuRun, n);
        exitIrq <= 1'h0;
        rdChk(IST, 32'h2, "exit status");
        watchdogHaltOption <= 1'h1;
        halt();
        waitHigh(watchdogReset, n);
        `CHK("run kept", 1'h1, cpuRun)
        $display("halt exits done");
        finishTest();
    end
endmodule
`default_nettype wire
